// ### scr_regs.sv
`timescale 1ns/1ps
module scr_regs
    import scr_pkg::*;
(
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_sys_rst,
    input  wire logic                       i_wr_en,
    input  wire logic                       i_rd_en,
    input  wire logic [scr_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [scr_pkg::DATA_W-1:0] i_wdata,
    output logic      [scr_pkg::DATA_W-1:0] o_rdata,
    input  wire logic [scr_pkg::POS_W-1:0]  i_edge_position_status,
    input  wire logic                       i_sysref,
    output logic                            o_sysref_aligned,
    output logic                            o_alignment_receiver_enable,
    output logic                            o_alignment_processor_enable,
    output logic                            o_window_fine_step,
    output logic      [3:0]                 o_capture_delay_select,
    output logic                            o_alignment_polarity_invert,
    output logic                            o_alignment_input_pecl_mode,
    output logic                            o_sample_clock_pecl_mode,
    output logic                            o_clock_rail_noise_suppress,
    output logic                            o_analog_rail_noise_suppress
);
    import scr_pkg::*;

    logic [7:0]       cap_reg, cap_next;
    logic [7:0]       mode_reg, mode_next;
    logic [7:0]       noise_reg, noise_next;
    logic [7:0]       rdata_reg, rdata_next;
    logic             align_reg, align_next;
    logic [POS_W-1:0] pos_sync;
    logic             ref_sync;

    // Status and SYSREF come from another domain, so both are synchronised
    scr_sync3 #(.W(POS_W)) u_pos_sync (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_edge_position_status),
        .o_sync    (pos_sync)
    );

    scr_sync3 #(.W(1)) u_ref_sync (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_sysref),
        .o_sync    (ref_sync)
    );

    // Writes to the status offsets fall through and change nothing
    always_comb begin
        cap_next   = cap_reg;
        mode_next  = mode_reg;
        noise_next = noise_reg;
        if (i_wr_en) begin
            if (i_addr == OFS_CAPTURE_CTRL) begin
                cap_next = i_wdata;
            end else if (i_addr == OFS_INPUT_MODE) begin
                mode_next = i_wdata;
            end else if (i_addr == OFS_NOISE_CTRL) begin
                noise_next = i_wdata;
            end
        end
    end

    // Byte-wide reads; unmapped offsets read as zero
    always_comb begin
        rdata_next = rdata_reg;
        if (i_rd_en) begin
            if (i_addr == OFS_CAPTURE_CTRL) begin
                rdata_next = cap_reg;
            end else if (i_addr == OFS_INPUT_MODE) begin
                rdata_next = mode_reg;
            end else if (i_addr == OFS_NOISE_CTRL) begin
                rdata_next = noise_reg;
            end else if (i_addr == OFS_POS_B0) begin
                rdata_next = pos_sync[7:0];
            end else if (i_addr == OFS_POS_B1) begin
                rdata_next = pos_sync[15:8];
            end else if (i_addr == OFS_POS_B2) begin
                rdata_next = pos_sync[23:16];
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    // Aligned SYSREF only passes while receiver and processor are both on;
    // gating on both tolerates a host that breaks the enable order
    always_comb begin
        align_next = 1'b0;
        if (cap_reg[BIT_PROC_EN] && cap_reg[BIT_RECV_EN]) begin
            align_next = ref_sync ^ mode_reg[BIT_INVERT];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            cap_reg   <= RST_CAPTURE_CTRL;
            mode_reg  <= RST_INPUT_MODE;
            noise_reg <= RST_NOISE_CTRL;
            rdata_reg <= 8'h00;
            align_reg <= 1'b0;
        end else begin
            cap_reg   <= cap_next;
            mode_reg  <= mode_next;
            noise_reg <= noise_next;
            rdata_reg <= rdata_next;
            align_reg <= align_next;
        end
    end

    assign o_rdata                      = rdata_reg;
    assign o_sysref_aligned             = align_reg;
    assign o_alignment_receiver_enable  = cap_reg[BIT_RECV_EN];
    assign o_alignment_processor_enable = cap_reg[BIT_PROC_EN];
    assign o_window_fine_step           = cap_reg[BIT_FINE_STEP];
    assign o_capture_delay_select       = cap_reg[SEL_MSB:0];
    assign o_alignment_polarity_invert  = mode_reg[BIT_INVERT];
    assign o_alignment_input_pecl_mode  = mode_reg[BIT_REF_PECL];
    assign o_sample_clock_pecl_mode     = mode_reg[BIT_CLK_PECL];
    assign o_clock_rail_noise_suppress  = noise_reg[BIT_CLK_RAIL];
    assign o_analog_rail_noise_suppress = noise_reg[BIT_ANA_RAIL];

    property p_proc_reset;
        @(posedge i_ref_clk) $fell(i_sys_rst) |-> !o_alignment_processor_enable;
    endproperty
    a_proc_reset: assert property (p_proc_reset)
        else $error("processor enable not clear after reset");

    property p_recv_write;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_wr_en && i_addr == OFS_CAPTURE_CTRL)
            |=> o_alignment_receiver_enable == $past(i_wdata[BIT_RECV_EN]);
    endproperty
    a_recv_write: assert property (p_recv_write)
        else $error("receiver enable did not follow write");

    property p_zoom_write;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_wr_en && i_addr == OFS_CAPTURE_CTRL)
            |=> o_window_fine_step == $past(i_wdata[BIT_FINE_STEP]);
    endproperty
    a_zoom_write: assert property (p_zoom_write)
        else $error("fine step bit did not follow write");

    property p_sel_reset;
        @(posedge i_ref_clk) i_sys_rst |=> o_capture_delay_select == 4'h0;
    endproperty
    a_sel_reset: assert property (p_sel_reset)
        else $error("delay select not zero after reset");

    property p_invert;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_alignment_processor_enable && o_alignment_receiver_enable)
            |=> o_sysref_aligned == ($past(ref_sync) ^ $past(mode_reg[0]));
    endproperty
    a_invert: assert property (p_invert)
        else $error("aligned sysref polarity wrong");

    property p_pos_ro;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_wr_en && i_addr == OFS_POS_B0)
            |=> $stable(cap_reg) && $stable(mode_reg) && $stable(noise_reg);
    endproperty
    a_pos_ro: assert property (p_pos_ro)
        else $error("write to status changed a register");

    property p_pos_read;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_rd_en && i_addr == OFS_POS_B2) |=> o_rdata == $past(pos_sync[23:16]);
    endproperty
    a_pos_read: assert property (p_pos_read)
        else $error("position top byte read wrong");

    property p_mode_write;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_wr_en && i_addr == OFS_INPUT_MODE) |=>
            o_sample_clock_pecl_mode == $past(i_wdata[2])
            && o_alignment_input_pecl_mode == $past(i_wdata[1]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("pecl mode bits did not follow write");

    property p_noise_reset;
        @(posedge i_ref_clk) i_sys_rst |=> !o_clock_rail_noise_suppress
            && !o_analog_rail_noise_suppress;
    endproperty
    a_noise_reset: assert property (p_noise_reset)
        else $error("noise suppress not clear after reset");
endmodule

// ### scr_pkg.sv
package scr_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned POS_W  = 24;

    localparam logic [7:0] OFS_CAPTURE_CTRL = 8'h29;
    localparam logic [7:0] OFS_INPUT_MODE   = 8'h2A;
    localparam logic [7:0] OFS_NOISE_CTRL   = 8'h2B;
    localparam logic [7:0] OFS_POS_B0       = 8'h2C;
    localparam logic [7:0] OFS_POS_B1       = 8'h2D;
    localparam logic [7:0] OFS_POS_B2       = 8'h2E;

    localparam logic [7:0] RST_CAPTURE_CTRL = 8'h80;
    localparam logic [7:0] RST_INPUT_MODE   = 8'h00;
    localparam logic [7:0] RST_NOISE_CTRL   = 8'h10;

    localparam int unsigned BIT_PROC_EN   = 6;
    localparam int unsigned BIT_RECV_EN   = 5;
    localparam int unsigned BIT_FINE_STEP = 4;
    localparam int unsigned SEL_MSB       = 3;
    localparam int unsigned BIT_INVERT    = 0;
    localparam int unsigned BIT_REF_PECL  = 1;
    localparam int unsigned BIT_CLK_PECL  = 2;
    localparam int unsigned BIT_CLK_RAIL  = 0;
    localparam int unsigned BIT_ANA_RAIL  = 2;
endpackage

// ### scr_sync3.sv
`timescale 1ns/1ps
module scr_sync3 #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg;
    logic [W-1:0] out_next;

    // Change accepted only once stages two and three agree
    always_comb begin
        out_next = out_reg;
        if (s2_reg == s3_reg) begin
            out_next = s3_reg;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            out_reg <= '0;
        end else begin
            s1_reg  <= i_async;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign o_sync = out_reg;
endmodule

// ### scr_host.sv
`timescale 1ns/1ps
module scr_host
    import scr_pkg::*;
(
    input  wire logic                       i_ref_clk,
    input  wire logic [scr_pkg::DATA_W-1:0] i_rdata,
    output logic                            o_wr_en,
    output logic                            o_rd_en,
    output logic      [scr_pkg::ADDR_W-1:0] o_addr,
    output logic      [scr_pkg::DATA_W-1:0] o_wdata
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr  = 8'h00;
        o_wdata = 8'h00;
    end
    // One strobe cycle; a released bus shows the inverse, never the old value
    task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        #1;
        o_wr_en = w;
        o_rd_en = !w;
        o_addr  = a;
        o_wdata = d;
        @(posedge i_ref_clk);
        #1;
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr  = ~a;
        o_wdata = ~d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == OFS_CAPTURE_CTRL) begin
            v = {1'b1, v[6], v[5] | v[6], v[4:0]};
            if (v[6])
                cyc(1'b1, a, v & 8'hBF);
        end
        if (a == OFS_INPUT_MODE)
            v = v & 8'h07;
        if (a == OFS_NOISE_CTRL)
            v = (v & 8'h05) | 8'h10;
        cyc(1'b1, a, v);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        cyc(1'b0, a, 8'h00);
        d = i_rdata;
    endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
    import scr_pkg::*;
    logic clk, rst, wr, rd, sr, al;
    logic [7:0] addr, wd, rdat, c, m, n, d;
    logic [23:0] pos;
    logic [12:0] outs;
    logic [31:0] seed;
    int n_mismatch, checks;
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    scr_regs dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_wr_en(wr),
        .i_rd_en(rd), .i_addr(addr), .i_wdata(wd), .o_rdata(rdat),
        .i_edge_position_status(pos), .i_sysref(sr),
        .o_sysref_aligned(al), .o_alignment_receiver_enable(outs[12]),
        .o_alignment_processor_enable(outs[11]),
        .o_window_fine_step(outs[10]), .o_capture_delay_select(outs[9:6]),
        .o_alignment_polarity_invert(outs[5]),
        .o_alignment_input_pecl_mode(outs[4]),
        .o_sample_clock_pecl_mode(outs[3]),
        .o_clock_rail_noise_suppress(outs[2]),
        .o_analog_rail_noise_suppress(outs[1]));
    assign outs[0] = 1'b0;
    scr_host h (.i_ref_clk(clk), .i_rdata(rdat), .o_wr_en(wr),
        .o_rd_en(rd), .o_addr(addr), .o_wdata(wd));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [12:0] eo(input logic [7:0] a, b, e);
        return {a[5], a[6], a[4], a[3:0], b[0], b[1], b[2], e[0], e[2], 1'b0};
    endfunction
    task automatic chk(input string nm, input logic [23:0] s, e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic rb(input logic [7:0] a, input logic [7:0] e);
        h.rd(a, d);
        chk("rdata", d, e);
    endtask
    task automatic do_rst();
        rst = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        chk("outs", outs, eo(8'h80, 8'h00, 8'h10));
        rb(8'h29, 8'h80);
        rb(8'h2A, 8'h00);
        rb(8'h2B, 8'h10);
        rb(8'h2F, 8'h00);
    endtask
    initial begin
        #200000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        seed = 32'h6315931F;
        sr = 1'b0;
        pos = 24'h000000;
        do_rst();
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            c = {1'b1, seed[6], seed[5] | seed[6], seed[4:0]};
            m = {5'h00, seed[10:8]};
            n = {3'h0, 1'b1, 1'b0, seed[13], 1'b0, seed[12]};
            h.wr(8'h29, c);
            h.wr(8'h2A, m);
            h.wr(8'h2B, n);
            chk("outs", outs, eo(c, m, n));
            rb(8'h29, c);
            rb(8'h2A, m);
            rb(8'h2B, n);
        end
        for (int k = 0; k < 4; k++) begin
            h.wr(8'h2A, {7'h00, k[0]});
            h.wr(8'h29, 8'hE0);
            sr = k[1];
            repeat (8) @(posedge clk);
            #1;
            chk("aligned", al, k[1] ^ k[0]);
        end
        // Ungated, both of these would show a one
        sr = 1'b0;
        h.wr(8'h29, 8'hA0);
        repeat (8) @(posedge clk);
        #1;
        chk("aligned", al, 1'b0);
        sr = 1'b1;
        h.wr(8'h2A, 8'h00);
        repeat (8) @(posedge clk);
        #1;
        chk("aligned", al, 1'b0);
        c = 8'hA0;
        for (int j = 0; j < 4; j++) begin
            seed = lfsr(seed);
            pos = (j == 0) ? 24'hFFFFFF : seed[23:0];
            repeat (6) @(posedge clk);
            h.cyc(1'b1, 8'h2C + j[1:0], 8'h5A);
            chk("outs", outs, eo(c, 8'h00, n));
            rb(8'h2C, pos[7:0]);
            rb(8'h2D, pos[15:8]);
            rb(8'h2E, pos[23:16]);
            c = {4'h9, pos[3:0]};
            h.wr(8'h29, c);
            chk("select", outs[9:6], pos[3:0]);
            chk("outs", outs, eo(c, 8'h00, n));
        end
        do_rst();
        end_sim();
    end
endmodule
